// file: swc_pkg.sv
// swc_pkg: states, timing counts and reset values for the sleep controller
// assumes a single 20 MHz clock domain
package swc_pkg;

  // ----------------------------------------------------------------------
  // power states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    SWC_RUN     = 4'b0001,
    SWC_LIGHT   = 4'b0010,
    SWC_DEEP    = 4'b0100,
    SWC_RESTORE = 4'b1000
  } swc_state_e;

  // ----------------------------------------------------------------------
  // timing and reset values
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  // wake and restore time out of deep sleep, in ns
  localparam int RESTORE_TIME_NS = 400;
  localparam int RESTORE_CYCLES =
    (RESTORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic EVENT_LATCH_RST = 1'b0;

endpackage

// file: swc_sleep_ctrl.sv
// swc_sleep_ctrl: processor sleep entry, wakeup and event latch control
// assumes the core pulses instruction strobes synchronous to clk_i and
// decides exception priority itself, presenting the results as levels
//
// Contract
// - light sleep stops only processor clock
// - deep sleep stops system clock, pll, flash
// - deep sleep select picks deep or light
// - wait-for-interrupt sleeps unless wake pending
// - one-bit event latch; clear latch sleeps
// - wait-for-event with set latch clears, continues
// - external event or send-event sets latch
// - event latch has no software access
// - sleep on handler exit enters sleep
// - interrupt-type sleep wakes on entry-priority exception
// - masked priority wakes but withholds handler
// - event sleep also wakes on events; in deep sleep with the wakeup detector active only irq_any_i wakes it
// - event on new pending wakes only event sleep
// - wakeup detector active only in deep sleep
// - wakeup detector has no registers
// - tick timer stopped while detector powers down
// - deep wake spends cycles restoring state
// - debugger connection disables wakeup detector
// - spurious wakes allowed; sleep re-enterable
`timescale 1ns/10ps
module swc_sleep_ctrl #(
  parameter int RESTORE_CYCLES = swc_pkg::RESTORE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic deep_sleep_select_i,
  input wire logic sleep_on_handler_exit_i,
  input wire logic event_on_new_pending_i,
  input wire logic priority_mask_bit_i,
  input wire logic fault_mask_bit_i,
  input wire logic wait_for_interrupt_instr_i,
  input wire logic wait_for_event_instr_i,
  input wire logic send_event_instr_i,
  input wire logic ext_event_i,
  input wire logic handler_exit_last_i,
  input wire logic exc_entry_ready_i,
  input wire logic irq_enabled_higher_i,
  input wire logic new_pending_i,
  input wire logic irq_any_i,
  input wire logic debug_connected_i,
  input wire logic debug_wake_i,
  output logic core_stall_o,
  output logic cpu_clk_en_o,
  output logic sys_clk_en_o,
  output logic pll_on_o,
  output logic flash_on_o,
  output logic core_power_down_o,
  output logic tick_timer_stop_o,
  output logic handler_hold_o,
  output logic wakeup_detector_active_o,
  output logic event_latch_o,
  output logic sleeping_o
);

  // ----------------------------------------------------------------------
  // wake conditions
  // ----------------------------------------------------------------------
  logic sleep_req;
  logic via_event;
  logic wake_exc;
  logic wake_evt;
  logic masked_wake;
  logic evt_in;

  // external input or this core's send-event instruction
  assign evt_in = ext_event_i | send_event_instr_i;
  // priority-masked interrupt wakes without handler entry
  assign masked_wake = priority_mask_bit_i & ~fault_mask_bit_i
                       & irq_enabled_higher_i;
  assign wake_exc = exc_entry_ready_i | masked_wake | debug_wake_i;
  assign wake_evt = wake_exc | evt_in
                    | (event_on_new_pending_i & new_pending_i);
  assign sleep_req = (wait_for_interrupt_instr_i & ~wake_exc)
                   | (wait_for_event_instr_i & ~event_latch_o)
                   | (sleep_on_handler_exit_i & handler_exit_last_i
                      & ~wake_exc);

  // ----------------------------------------------------------------------
  // event latch; no register path reaches it
  // ----------------------------------------------------------------------
  logic evt_reg;
  logic evt_next;

  always_comb
  begin
    evt_next = evt_reg;
    if (wait_for_event_instr_i)
      evt_next = 1'b0;
    // set wins over the clear from a simultaneous wait-for-event
    if (evt_in | (event_on_new_pending_i & new_pending_i))
      evt_next = 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      evt_reg <= swc_pkg::EVENT_LATCH_RST;
    else
      evt_reg <= evt_next;
  end

  // ----------------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------------
  swc_pkg::swc_state_e state_reg;
  swc_pkg::swc_state_e state_next;
  logic via_event_reg;
  logic via_event_next;
  logic wic_reg;
  logic wic_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic wake_now;

  assign via_event = wait_for_event_instr_i & ~event_latch_o;
  assign wake_now = via_event_reg ? wake_evt : wake_exc;

  always_comb
  begin
    state_next = state_reg;
    via_event_next = via_event_reg;
    wic_next = wic_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      swc_pkg::SWC_RUN:
      begin
        if (sleep_req)
        begin
          via_event_next = via_event;
          if (deep_sleep_select_i)
          begin
            state_next = swc_pkg::SWC_DEEP;
            wic_next = ~debug_connected_i;
          end
          else
            state_next = swc_pkg::SWC_LIGHT;
        end
      end
      swc_pkg::SWC_LIGHT:
      begin
        if (wake_now)
          state_next = swc_pkg::SWC_RUN;
      end
      swc_pkg::SWC_DEEP:
      begin
        if (debug_connected_i)
          wic_next = 1'b0;
        // powered-down core: only the detector sees interrupts
        if (wic_reg ? (irq_any_i & ~debug_connected_i) : wake_now)
        begin
          state_next = swc_pkg::SWC_RESTORE;
          // detector steps down as the system clock returns
          wic_next = 1'b0;
          cnt_next = 16'(RESTORE_CYCLES - 1);
        end
      end
      swc_pkg::SWC_RESTORE:
      begin
        wic_next = 1'b0;
        if (cnt_reg == 16'h0000)
          state_next = swc_pkg::SWC_RUN;
        else
          cnt_next = cnt_reg - 16'h0001;
      end
      default:
        state_next = swc_pkg::SWC_RUN;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= swc_pkg::SWC_RUN;
      via_event_reg <= 1'b0;
      wic_reg <= 1'b0;
      cnt_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      via_event_reg <= via_event_next;
      wic_reg <= wic_next;
      cnt_reg <= cnt_next;
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  logic asleep_next;
  logic deep_next;
  logic hold_reg;
  logic hold_next;

  assign asleep_next = state_next != swc_pkg::SWC_RUN;
  assign deep_next = state_next == swc_pkg::SWC_DEEP;
  // handler waits while the priority mask stays set after a masked wake
  assign hold_next = priority_mask_bit_i
                     & (hold_reg | (masked_wake & asleep_next == 1'b0
                        & state_reg != swc_pkg::SWC_RUN));

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      core_stall_o <= 1'b0;
      cpu_clk_en_o <= 1'b1;
      sys_clk_en_o <= 1'b1;
      pll_on_o <= 1'b1;
      flash_on_o <= 1'b1;
      core_power_down_o <= 1'b0;
      tick_timer_stop_o <= 1'b0;
      hold_reg <= 1'b0;
      wakeup_detector_active_o <= 1'b0;
      event_latch_o <= swc_pkg::EVENT_LATCH_RST;
      sleeping_o <= 1'b0;
    end
    else
    begin
      core_stall_o <= asleep_next;
      cpu_clk_en_o <= ~asleep_next;
      sys_clk_en_o <= ~deep_next;
      pll_on_o <= ~deep_next;
      flash_on_o <= ~deep_next;
      core_power_down_o <= deep_next & wic_next;
      tick_timer_stop_o <= deep_next & wic_next;
      hold_reg <= hold_next;
      wakeup_detector_active_o <= wic_next;
      event_latch_o <= evt_next;
      sleeping_o <= asleep_next;
    end
  end

  assign handler_hold_o = hold_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_deep_wake;
    state_reg == swc_pkg::SWC_DEEP && state_next == swc_pkg::SWC_RESTORE;
  endsequence

  a_light_clocks: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == swc_pkg::SWC_LIGHT |-> !cpu_clk_en_o && sys_clk_en_o)
    else $error("light sleep clock gating wrong");
  a_deep_clocks: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == swc_pkg::SWC_DEEP |-> !sys_clk_en_o && !pll_on_o
      && !flash_on_o)
    else $error("deep sleep left clocks running");
  a_mode_select: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == swc_pkg::SWC_RUN && sleep_req |=>
      (state_reg == swc_pkg::SWC_DEEP) == $past(deep_sleep_select_i))
    else $error("sleep mode select ignored");
  a_wfi_pending: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == swc_pkg::SWC_RUN && wait_for_interrupt_instr_i && wake_exc
      && !wait_for_event_instr_i && !sleep_on_handler_exit_i
      |=> state_reg == swc_pkg::SWC_RUN)
    else $error("wfi slept with wake pending");
  a_wfe_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    wait_for_event_instr_i && event_latch_o && !evt_in && !new_pending_i
      |=> !event_latch_o)
    else $error("event latch not cleared");
  a_event_set: assert property (@(posedge clk_i) disable iff (rst_i)
    evt_in |=> event_latch_o)
    else $error("event latch not set");
  a_deep_restore: assert property (@(posedge clk_i) disable iff (rst_i)
    s_deep_wake |=> (state_reg == swc_pkg::SWC_RESTORE) [*2])
    else $error("restore period too short");
  a_debug_wic: assert property (@(posedge clk_i) disable iff (rst_i)
    debug_connected_i |=> !wakeup_detector_active_o)
    else $error("wakeup detector active under debug");
  a_wic_deep: assert property (@(posedge clk_i) disable iff (rst_i)
    wakeup_detector_active_o |-> !sys_clk_en_o)
    else $error("wakeup detector active outside deep sleep");

endmodule

// file: swc_pmu_model.sv
// swc_pmu_model: stand-in for the power management unit and a peripheral
// assumes bench requests change only at the falling edge of clk_i
`timescale 1ns/10ps
module swc_pmu_model (
  input wire logic clk_i,
  input wire logic ev_req_i,
  input wire logic irq_req_i,
  input wire logic tick_stop_i,
  output logic ext_event_o,
  output logic irq_any_o,
  output logic [7:0] tick_o
);
  logic ev_q;
  logic irq_q;
  initial
  begin
    ev_q = 1'b0;
    irq_q = 1'b0;
    ext_event_o = 1'b0;
    irq_any_o = 1'b0;
    tick_o = 8'h00;
  end
  // a slow peripheral: lines follow requests one cycle late
  always @(posedge clk_i)
  begin
    ev_q <= ev_req_i;
    irq_q <= irq_req_i;
  end
  always @(negedge clk_i)
  begin
    ext_event_o <= ev_q;
    irq_any_o <= irq_q;
    if (!tick_stop_i)
      tick_o <= tick_o + 8'h01;
  end
endmodule

// file: tb_swc_sleep_ctrl.sv
// tb_swc_sleep_ctrl: self-checking bench for the sleep controller
// assumes the partner model drives the event and irq lines
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module tb_swc_sleep_ctrl;
  localparam int RC = 3;
  logic clk_i, rst_i, dsel, soe, eonp, pmask, fmask, wait_for_interrupt_instr, wait_for_event_instr, send_event_instr, hexit;
  logic exc_rdy, irq_hi, newp, dbg_con, dbg_wake, ev_req, irq_req, ext_ev;
  logic irq_any, stall, cpu_clk, sys_clk, pll, flash, pdown, tstop, hold;
  logic det, latch, sleeping;
  logic [7:0] tick, tk;
  int n_fail = 0;
  int checks_done = 0;
  int n;
  swc_sleep_ctrl #(.RESTORE_CYCLES(RC)) i_swc_sleep_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .deep_sleep_select_i(dsel),
    .sleep_on_handler_exit_i(soe), .event_on_new_pending_i(eonp),
    .priority_mask_bit_i(pmask), .fault_mask_bit_i(fmask),
    .wait_for_interrupt_instr_i(wait_for_interrupt_instr), .wait_for_event_instr_i(wait_for_event_instr),
    .send_event_instr_i(send_event_instr), .ext_event_i(ext_ev),
    .handler_exit_last_i(hexit), .exc_entry_ready_i(exc_rdy),
    .irq_enabled_higher_i(irq_hi), .new_pending_i(newp),
    .irq_any_i(irq_any), .debug_connected_i(dbg_con),
    .debug_wake_i(dbg_wake), .core_stall_o(stall), .cpu_clk_en_o(cpu_clk),
    .sys_clk_en_o(sys_clk), .pll_on_o(pll), .flash_on_o(flash),
    .core_power_down_o(pdown), .tick_timer_stop_o(tstop),
    .handler_hold_o(hold), .wakeup_detector_active_o(det),
    .event_latch_o(latch), .sleeping_o(sleeping));
  swc_pmu_model i_swc_pmu_model (.clk_i(clk_i), .ev_req_i(ev_req),
    .irq_req_i(irq_req), .tick_stop_i(tstop), .ext_event_o(ext_ev),
    .irq_any_o(irq_any), .tick_o(tick));
  function automatic logic exp_on(input logic slp, input logic deep);
    return !(slp && deep);
  endfunction
  task automatic step(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic chk_mode(input logic slp, input logic deep);
    `CHK(sleeping, slp)
    `CHK(cpu_clk, ~slp)
    `CHK(sys_clk, exp_on(slp, deep))
    `CHK(pll, exp_on(slp, deep))
    `CHK(flash, exp_on(slp, deep))
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // generous bound: the whole sequence needs at most some 90 cycles
  initial
  begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    summarize();
  end
  initial
  begin
    {dsel, soe, eonp, pmask, fmask, wait_for_interrupt_instr, wait_for_event_instr, send_event_instr, hexit} = 9'h000;
    {exc_rdy, irq_hi, newp, dbg_con, dbg_wake, ev_req, irq_req} = 7'h00;
    rst_i = 1'b1;
    n = $urandom(32'hc8b2);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    `CHK(latch, 1'b0)
    chk_mode(1'b0, 1'b0);
    pulse(wait_for_event_instr);
    chk_mode(1'b1, 1'b0);
    pulse(ev_req);
    step(1);
    chk_mode(1'b0, 1'b0);
    `CHK(latch, 1'b1)
    // latch set by random sources and spacing, then consumed
    for (int j = 0; j < 8; j++)
    begin
      if ($urandom_range(1, 0) == 1)
        pulse(send_event_instr);
      else
        pulse(ev_req);
      step($urandom_range(3, 1));
      `CHK(latch, 1'b1)
      pulse(wait_for_event_instr);
      `CHK(sleeping, 1'b0)
      `CHK(latch, 1'b0)
    end
    exc_rdy = 1'b1;
    pulse(wait_for_interrupt_instr);
    `CHK(sleeping, 1'b0)
    exc_rdy = 1'b0;
    pulse(wait_for_interrupt_instr);
    `CHK(sleeping, 1'b1)
    pulse(ev_req);
    step(3);
    `CHK(sleeping, 1'b1)
    pulse(exc_rdy);
    `CHK(sleeping, 1'b0)
    pulse(wait_for_event_instr);
    pmask = 1'b1;
    pulse(wait_for_interrupt_instr);
    pulse(irq_hi);
    `CHK(sleeping, 1'b0)
    step(2);
    `CHK(hold, 1'b1)
    pmask = 1'b0;
    step(2);
    `CHK(hold, 1'b0)
    {pmask, fmask} = 2'b11;
    pulse(wait_for_interrupt_instr);
    pulse(irq_hi);
    `CHK(sleeping, 1'b1)
    pulse(exc_rdy);
    {pmask, fmask} = 2'b00;
    soe = 1'b1;
    pulse(hexit);
    soe = 1'b0;
    `CHK(sleeping, 1'b1)
    pulse(dbg_wake);
    `CHK(sleeping, 1'b0)
    pulse(wait_for_interrupt_instr);
    `CHK(sleeping, 1'b1)
    pulse(exc_rdy);
    pulse(wait_for_event_instr);
    `CHK(sleeping, 1'b1)
    pulse(newp);
    `CHK(sleeping, 1'b1)
    eonp = 1'b1;
    pulse(newp);
    eonp = 1'b0;
    `CHK(sleeping, 1'b0)
    pulse(wait_for_event_instr);
    dsel = 1'b1;
    pulse(wait_for_interrupt_instr);
    chk_mode(1'b1, 1'b1);
    `CHK(det, 1'b1)
    `CHK(pdown, 1'b1)
    `CHK(tstop, 1'b1)
    tk = tick;
    step(3);
    `CHK(tick, tk)
    pulse(irq_req);
    step(1);
    `CHK(stall, 1'b1)
    `CHK(sys_clk, 1'b1)
    n = 0;
    while (stall === 1'b1 && n < 20)
    begin
      step(1);
      n++;
    end
    `CHK(n, RC)
    dbg_con = 1'b1;
    pulse(wait_for_interrupt_instr);
    `CHK(det, 1'b0)
    `CHK(pdown, 1'b0)
    pulse(exc_rdy);
    `CHK(sleeping, 1'b1)
    step(RC);
    `CHK(sleeping, 1'b0)
    summarize();
  end
endmodule
